// ===== verilog/rbd_pkg.sv
`default_nettype none

package rbd_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int WORD_W      = 16;
  localparam int MOD_ADDR_W  = 12;
  localparam int ADDR_W      = 13;
  localparam int SIGN_BIT    = 15;
  localparam int CARRY_BIT   = 14;

  // Machine cycle times in nanoseconds and derived clock counts
  localparam int CLK_NS          = 8;
  localparam int SHORT_STEP_NS   = 2000;
  localparam int LONG_STEP_NS    = 4000;
  localparam int CYCLE_CLKS      = SHORT_STEP_NS / CLK_NS;
  localparam int LONG_STEP_CLKS  = LONG_STEP_NS / CLK_NS;

  // Address of the two accumulators when addressed as memory
  localparam logic [ADDR_W-1:0] ADDR_FIRST_ACC  = 13'h0000;
  localparam logic [ADDR_W-1:0] ADDR_SECOND_ACC = 13'h0001;

  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_ONE  = 16'h0001;
  localparam logic [WORD_W-1:0] WORD_TWO  = 16'h0002;

  // ************************************************************
  // Bus sources and functions
  // ************************************************************
  typedef enum logic [2:0] {
    RBD_SRC_ZERO  = 3'b000,
    RBD_SRC_FIRST = 3'b001,
    RBD_SRC_SECND = 3'b010,
    RBD_SRC_PC    = 3'b011,
    RBD_SRC_MAR   = 3'b100,
    RBD_SRC_MDR   = 3'b101,
    RBD_SRC_EXT   = 3'b110
  } rbd_src_e;

  typedef enum logic [3:0] {
    RBD_FN_PASS_R = 4'h0,
    RBD_FN_PASS_S = 4'h1,
    RBD_FN_ADD    = 4'h2,
    RBD_FN_AND    = 4'h3,
    RBD_FN_XOR    = 4'h4,
    RBD_FN_IOR    = 4'h5,
    RBD_FN_CMPL   = 4'h6,
    RBD_FN_SHL    = 4'h7,
    RBD_FN_SHR    = 4'h8,
    RBD_FN_ROL    = 4'h9,
    RBD_FN_ROR    = 4'ha,
    RBD_FN_ROL32  = 4'hb,
    RBD_FN_ROR32  = 4'hc,
    RBD_FN_INC    = 4'hd,
    RBD_FN_INC2   = 4'he,
    RBD_FN_CMPEQ  = 4'hf
  } rbd_fn_e;

  typedef enum logic [1:0] {
    RBD_MS_IDLE  = 2'b00,
    RBD_MS_CLEAR = 2'b01,
    RBD_MS_READ  = 2'b10,
    RBD_MS_WRITE = 2'b11
  } rbd_mstate_e;

  // Store enables for the result bus, one per register
  typedef struct packed {
    logic first_acc;
    logic second_acc;
    logic pc;
    logic mar;
    logic mdr;
  } rbd_store_s;

  // One micro-step from the instruction logic
  typedef struct packed {
    logic       valid;
    rbd_src_e   r_src;
    rbd_src_e   s_src;
    rbd_fn_e    fn;
    rbd_store_s store;
    logic       clear_ext;
    logic       clear_ovf;
    logic       mem_start;
    logic       mem_write;
  } rbd_cmd_s;

endpackage

`default_nettype wire

// ===== verilog/rbd_datapath.sv
// What this block does
// - Memory word is sixteen bits, moved whole in one access.
// - Each bit has a 4096-location plane; one addressed location accessed.
// - A seventeenth plane holds one parity bit per word.
// - Addressing is flat; pages have no physical effect.
// - Data register captures reads, supplies writes late in the cycle.
// - Program counter steps by one, or two on skip.
// - Jump loads program counter from another register via the buses.
// - Instructions take one or two machine cycles, 2.0 or 4.0 us.
// - Memory addressed only by address register, loaded from counter.
// - Address register reloads (not during a memory cycle) while counter holds instruction location.
// - After operand instruction, counter increments, both registers get it.
// - First accumulator supports add, boolean, compare, shifts, test, complement, I/O.
// - Second accumulator has all those except the three boolean operations.
// - Extend flag sets on carry out of bit 15.
// - Extend clearable, and links both accumulators for 32-bit shifts.
// - Positive plus positive with carry into sign sets overflow.
// - Negative plus negative without carry into sign sets overflow.
// - Opposite-sign addition never sets overflow.
// - Internal buses are sixteen bits wide.
// - Two source buses feed the ALU, result bus writes back.
// - Registers load from the result bus; accumulators also from I/O input, data register from memory.
// - Accumulators addressable as memory, readable into the data register.
// - Data register clears at the start of every memory cycle.
// - Low twelve bits address a module, bit 12 selects second module.
`timescale 1ns/1ns
`default_nettype none

module rbd_datapath #(
  parameter int MODULES = 2
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire rbd_pkg::rbd_cmd_s           cmd,
  input  wire logic                        io_in_en,
  input  wire logic [rbd_pkg::WORD_W-1:0]  io_in_data,
  output logic [rbd_pkg::WORD_W-1:0]       first_acc,
  output logic [rbd_pkg::WORD_W-1:0]       second_acc,
  output logic [rbd_pkg::WORD_W-1:0]       pc,
  output logic [rbd_pkg::ADDR_W-1:0]       mar,
  output logic [rbd_pkg::WORD_W-1:0]       mdr,
  output logic                             ext_flag,
  output logic                             ovf_flag,
  output logic                             cmp_equal,
  output logic                             parity_err,
  output logic                             mem_busy
);
  import rbd_pkg::*;

  localparam int DEPTH = MODULES << MOD_ADDR_W;
  localparam logic [7:0] CYC_LAST  = 8'(CYCLE_CLKS - 1);
  localparam logic [7:0] CYC_HALF  = 8'(CYCLE_CLKS / 2);

  // ************************************************************
  // Storage planes
  // ************************************************************
  logic [WORD_W-1:0] data_plane [DEPTH];
  logic              parity_plane [DEPTH];

  logic [WORD_W-1:0] first_acc_r, second_acc_r, pc_r, mdr_r;
  logic [ADDR_W-1:0] mar_r;
  logic              ext_r, ovf_r, cmp_r, perr_r, busy_r, wr_r;
  rbd_mstate_e       ms_r;
  logic [7:0]        cyc_r;

  // ************************************************************
  // Source buses
  // ************************************************************
  function automatic logic [WORD_W-1:0] src_sel(input rbd_src_e s,
                                                input logic [WORD_W-1:0] fa,
                                                input logic [WORD_W-1:0] sa,
                                                input logic [WORD_W-1:0] p,
                                                input logic [ADDR_W-1:0] m,
                                                input logic [WORD_W-1:0] t,
                                                input logic e);
    logic [WORD_W-1:0] v;
    v = WORD_ZERO;
    if (s == RBD_SRC_FIRST)
      v = fa;
    else if (s == RBD_SRC_SECND)
      v = sa;
    else if (s == RBD_SRC_PC)
      v = p;
    else if (s == RBD_SRC_MAR)
      v = WORD_W'(m);
    else if (s == RBD_SRC_MDR)
      v = t;
    else if (s == RBD_SRC_EXT)
      v = WORD_W'(e);
    return v;
  endfunction

  logic [WORD_W-1:0] r_bus, s_bus, t_bus;
  logic              alu_carry, alu_ovf, alu_sets_ext, alu_sets_ovf, alu_ext_val;

  assign r_bus = src_sel(cmd.r_src, first_acc_r, second_acc_r, pc_r, mar_r, mdr_r, ext_r);
  assign s_bus = src_sel(cmd.s_src, first_acc_r, second_acc_r, pc_r, mar_r, mdr_r, ext_r);

  // ************************************************************
  // Arithmetic logic
  // ************************************************************
  // Boolean ops apply unless the result targets the second accumulator
  logic bool_ok;
  assign bool_ok = !cmd.store.second_acc;

  always_comb
  begin
    logic [WORD_W:0] sum;
    logic            c14;
    sum          = '0;
    c14          = 1'b0;
    t_bus        = WORD_ZERO;
    alu_carry    = 1'b0;
    alu_ovf      = 1'b0;
    alu_sets_ext = 1'b0;
    alu_sets_ovf = 1'b0;
    alu_ext_val  = ext_r;
    case (cmd.fn)
      RBD_FN_PASS_R: t_bus = r_bus;
      RBD_FN_PASS_S: t_bus = s_bus;
      RBD_FN_ADD:
      begin
        // R and S combined onto T
        sum = {1'b0, r_bus} + {1'b0, s_bus};
        c14 = r_bus[SIGN_BIT] ^ s_bus[SIGN_BIT] ^ sum[SIGN_BIT];
        t_bus        = sum[WORD_W-1:0];
        alu_carry    = sum[WORD_W];
        alu_sets_ext = 1'b1;
        alu_sets_ovf = 1'b1;
        alu_ovf = (!r_bus[SIGN_BIT] && !s_bus[SIGN_BIT] && c14) ||
                  (r_bus[SIGN_BIT] && s_bus[SIGN_BIT] && !c14);
      end
      RBD_FN_AND:  t_bus = bool_ok ? (r_bus & s_bus) : r_bus;
      RBD_FN_XOR:  t_bus = bool_ok ? (r_bus ^ s_bus) : r_bus;
      RBD_FN_IOR:  t_bus = bool_ok ? (r_bus | s_bus) : r_bus;
      RBD_FN_CMPL: t_bus = ~r_bus;
      RBD_FN_SHL:  t_bus = {r_bus[WORD_W-2:0], 1'b0};
      RBD_FN_SHR:  t_bus = {1'b0, r_bus[WORD_W-1:1]};
      RBD_FN_ROL:  t_bus = {r_bus[WORD_W-2:0], r_bus[WORD_W-1]};
      RBD_FN_ROR:  t_bus = {r_bus[0], r_bus[WORD_W-1:1]};
      RBD_FN_ROL32:
      begin
        // Extend links the accumulators: R is high half, S low half
        t_bus        = {r_bus[WORD_W-2:0], s_bus[WORD_W-1]};
        alu_sets_ext = 1'b1;
        alu_ext_val  = r_bus[WORD_W-1];
      end
      RBD_FN_ROR32:
      begin
        t_bus        = {ext_r, r_bus[WORD_W-1:1]};
        alu_sets_ext = 1'b1;
        alu_ext_val  = r_bus[0];
      end
      RBD_FN_INC:
      begin
        sum       = {1'b0, r_bus} + {1'b0, WORD_ONE};
        t_bus     = sum[WORD_W-1:0];
      end
      RBD_FN_INC2:
      begin
        sum       = {1'b0, r_bus} + {1'b0, WORD_TWO};
        t_bus     = sum[WORD_W-1:0];
      end
      RBD_FN_CMPEQ: t_bus = r_bus;
      default:      t_bus = r_bus;
    endcase
    if (cmd.fn == RBD_FN_ADD)
      alu_ext_val = alu_carry;
  end

  // ************************************************************
  // Working registers, loaded from the result bus or, for the accumulators, I/O input
  // ************************************************************
  logic go;
  assign go = cmd.valid;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      first_acc_r  <= WORD_ZERO;
      second_acc_r <= WORD_ZERO;
    end
    else if (go)
    begin
      // I/O input data bypasses the result bus straight into the accumulators
      if (cmd.store.first_acc)
        first_acc_r <= io_in_en ? io_in_data : t_bus;
      if (cmd.store.second_acc)
        second_acc_r <= io_in_en ? io_in_data : t_bus;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pc_r <= WORD_ZERO;
    else if (go && cmd.store.pc)
      pc_r <= t_bus;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mar_r <= '0;
    else if (go && cmd.store.mar && !busy_r)
      mar_r <= t_bus[ADDR_W-1:0];  // flat address
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_r <= 1'b0;
      ovf_r <= 1'b0;
      cmp_r <= 1'b0;
    end
    else if (go)
    begin
      if (cmd.clear_ext)
        ext_r <= 1'b0;
      else if (alu_sets_ext && (cmd.store.first_acc || cmd.store.second_acc))
        ext_r <= (cmd.fn == RBD_FN_ADD) ? (ext_r | alu_ext_val) : alu_ext_val;
      if (cmd.clear_ovf)
        ovf_r <= 1'b0;
      else if (alu_sets_ovf && (cmd.store.first_acc || cmd.store.second_acc))
        ovf_r <= ovf_r | alu_ovf;
      if (cmd.fn == RBD_FN_CMPEQ)
        cmp_r <= (r_bus == s_bus);
    end
  end

  // ************************************************************
  // Memory cycle: clear, read half, write half
  // ************************************************************
  logic [ADDR_W-1:0] addr;
  logic              acc_addr, mod_ok;
  logic [WORD_W-1:0] rd_word;
  assign addr     = mar_r;
  assign acc_addr = (addr == ADDR_FIRST_ACC) || (addr == ADDR_SECOND_ACC);
  // bit 12 picks a module, only when fitted
  assign mod_ok   = 32'(addr[ADDR_W-1]) < MODULES;
  assign rd_word  = (addr == ADDR_FIRST_ACC)  ? first_acc_r :
                    (addr == ADDR_SECOND_ACC) ? second_acc_r :
                    (mod_ok ? data_plane[addr] : WORD_ZERO);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ms_r   <= RBD_MS_IDLE;
      cyc_r  <= '0;
      busy_r <= 1'b0;
      wr_r   <= 1'b0;
    end
    else
    begin
      case (ms_r)
        RBD_MS_IDLE:
          if (go && cmd.mem_start)
          begin
            ms_r   <= RBD_MS_CLEAR;
            busy_r <= 1'b1;
            wr_r   <= cmd.mem_write;
            cyc_r  <= '0;
          end
        RBD_MS_CLEAR:
        begin
          ms_r  <= RBD_MS_READ;
          cyc_r <= cyc_r + 8'h01;
        end
        RBD_MS_READ:
        begin
          cyc_r <= cyc_r + 8'h01;
          if (cyc_r == CYC_HALF)
            ms_r <= RBD_MS_WRITE;
        end
        RBD_MS_WRITE:
        begin
          cyc_r <= cyc_r + 8'h01;
          if (cyc_r == CYC_LAST)
          begin
            ms_r   <= RBD_MS_IDLE;  // one cycle = 2.0 us
            busy_r <= 1'b0;
          end
        end
        default: ms_r <= RBD_MS_IDLE;
      endcase
    end
  end

  // Data register: cleared at start, sensed, or loaded from the result bus
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mdr_r  <= WORD_ZERO;
      perr_r <= 1'b0;
    end
    else if (ms_r == RBD_MS_CLEAR)
      mdr_r <= WORD_ZERO;
    else if (ms_r == RBD_MS_READ && cyc_r == CYC_HALF && !wr_r)
    begin
      mdr_r  <= rd_word;  // whole word in parallel
      perr_r <= !acc_addr && mod_ok && ((^data_plane[addr]) != parity_plane[addr]);
    end
    else if (go && cmd.store.mdr)
      mdr_r <= t_bus;
  end

  // Write-back during second half of the cycle
  always_ff @(posedge clk)
  begin
    if (ms_r == RBD_MS_WRITE && cyc_r == CYC_LAST && !acc_addr && mod_ok)
    begin
      data_plane[addr]   <= mdr_r;  // one location per plane
      parity_plane[addr] <= ^mdr_r;
    end
  end

  assign first_acc  = first_acc_r;
  assign second_acc = second_acc_r;
  assign pc         = pc_r;
  assign mar        = mar_r;
  assign mdr        = mdr_r;
  assign ext_flag   = ext_r;
  assign ovf_flag   = ovf_r;
  assign cmp_equal  = cmp_r;
  assign parity_err = perr_r;
  assign mem_busy   = busy_r;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  mdr_clear_a: assert property ((ms_r == RBD_MS_CLEAR) |=> (mdr_r == WORD_ZERO))
    else $error("data register not cleared at cycle start");
  cycle_len_a: assert property ($rose(busy_r) |-> ##249 busy_r ##1 !busy_r)
    else $error("memory cycle length wrong");
  pc_hold_a: assert property ((go && !cmd.store.pc) |=> $stable(pc_r))
    else $error("program counter changed without store");
  skip_two_a: assert property ((go && cmd.store.pc && cmd.fn == RBD_FN_INC2
                                && cmd.r_src == RBD_SRC_PC) |=> pc_r == $past(pc_r) + WORD_TWO)
    else $error("skip did not add two");
  ext_carry_a: assert property ((go && cmd.fn == RBD_FN_ADD && cmd.store.first_acc && !cmd.clear_ext
                                 && alu_carry) |=> ext_r)
    else $error("carry did not set extend");
  ovf_mixed_a: assert property ((go && cmd.fn == RBD_FN_ADD && !cmd.clear_ovf && !ovf_r
                                 && (r_bus[SIGN_BIT] != s_bus[SIGN_BIT])) |=> !ovf_r)
    else $error("mixed signs set overflow");
  ovf_pos_a: assert property ((go && cmd.fn == RBD_FN_ADD && cmd.store.first_acc && !cmd.clear_ovf
                               && !r_bus[SIGN_BIT] && !s_bus[SIGN_BIT] && t_bus[SIGN_BIT]) |=> ovf_r)
    else $error("positive overflow missed");
  ovf_neg_a: assert property ((go && cmd.fn == RBD_FN_ADD && cmd.store.first_acc && !cmd.clear_ovf
                               && r_bus[SIGN_BIT] && s_bus[SIGN_BIT] && !t_bus[SIGN_BIT]) |=> ovf_r)
    else $error("negative overflow missed");
  ext_clear_a: assert property ((go && cmd.clear_ext) |=> !ext_r)
    else $error("extend not cleared");
  mar_stable_a: assert property (busy_r |=> (busy_r ? $stable(mar_r) : 1'b1))
    else $error("address changed mid cycle");

  read_c:  cover property ($rose(busy_r) && !wr_r);
  write_c: cover property ($rose(busy_r) && wr_r);
  ovf_c:   cover property ($rose(ovf_r));
  rot_c:   cover property (go && cmd.fn == RBD_FN_ROL32);

endmodule // rbd_datapath

`default_nettype wire

// ===== dv/rbd_mem_model.sv
`timescale 1ns/1ns
`default_nettype none

module rbd_mem_model;
  import rbd_pkg::*;

  // ************************************************************
  // Storage planes
  // ************************************************************
  // Sixteen data planes and one parity plane, indexed by the flat address
  logic [WORD_W:0] plane [logic [ADDR_W-1:0]];

  // Whole word and its parity go in together
  task automatic put(
    input logic [ADDR_W-1:0] addr,
    input logic [WORD_W-1:0] data
  );
    plane[addr] = {^data, data};
  endtask

  // Bit 12 of the address picks the second module, no page effect
  function automatic logic [WORD_W-1:0] get(
    input logic [ADDR_W-1:0] addr,
    input logic [WORD_W-1:0] fa,
    input logic [WORD_W-1:0] sa
  );
    if (addr == ADDR_FIRST_ACC)
      return fa;
    if (addr == ADDR_SECOND_ACC)
      return sa;
    if (!plane.exists(addr))
      return WORD_ZERO;
    return plane[addr][WORD_W-1:0];
  endfunction

endmodule // rbd_mem_model

`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_top;
  import rbd_pkg::*;

  localparam logic [4:0] ST_A = 5'h10;
  localparam logic [4:0] ST_B = 5'h08;
  localparam logic [4:0] ST_PC = 5'h04;
  localparam logic [4:0] ST_MAR = 5'h02;
  localparam logic [4:0] ST_MDR = 5'h01;

  logic              clk;
  logic              rst_n;
  rbd_cmd_s          cmd;
  logic              io_in_en;
  logic [WORD_W-1:0] io_in_data;
  logic [WORD_W-1:0] first_acc;
  logic [WORD_W-1:0] second_acc;
  logic [WORD_W-1:0] pc;
  logic [ADDR_W-1:0] mar;
  logic [WORD_W-1:0] mdr;
  logic              ext_flag;
  logic              ovf_flag;
  logic              cmp_equal;
  logic              parity_err;
  logic              mem_busy;
  int                miscompares;
  int                total_checks;
  int                cyc;
  int                busy_cnt;
  int                i;
  int                n;
  logic [31:0]       seed;
  logic [WORD_W-1:0] a;
  logic [WORD_W-1:0] b;
  logic [WORD_W:0]   sum;
  logic [ADDR_W-1:0] adr [3];
  logic [WORD_W-1:0] dat [3];
  rbd_cmd_s          c;
  rbd_fn_e           fl [8];

  rbd_datapath u_rbd_datapath (
    .clk        (clk),
    .rst_n      (rst_n),
    .cmd        (cmd),
    .io_in_en   (io_in_en),
    .io_in_data (io_in_data),
    .first_acc  (first_acc),
    .second_acc (second_acc),
    .pc         (pc),
    .mar        (mar),
    .mdr        (mdr),
    .ext_flag   (ext_flag),
    .ovf_flag   (ovf_flag),
    .cmp_equal  (cmp_equal),
    .parity_err (parity_err),
    .mem_busy   (mem_busy)
  );

  rbd_mem_model u_rbd_mem_model ();

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic rbd_cmd_s mk(input rbd_src_e r, input rbd_src_e s, input rbd_fn_e f,
                                  input logic [4:0] st);
    rbd_cmd_s m;
    m = '0;
    m.valid = 1'b1;
    m.r_src = r;
    m.s_src = s;
    m.fn = f;
    m.store = st;
    return m;
  endfunction

  function automatic logic [WORD_W-1:0] exp_fn(input rbd_fn_e f, input logic [15:0] x,
                                               input logic [15:0] y);
    case (f)
      RBD_FN_AND:  return x & y;
      RBD_FN_XOR:  return x ^ y;
      RBD_FN_IOR:  return x | y;
      RBD_FN_CMPL: return ~x;
      RBD_FN_SHL:  return {x[14:0], 1'b0};
      RBD_FN_SHR:  return {1'b0, x[15:1]};
      RBD_FN_ROL:  return {x[14:0], x[15]};
      RBD_FN_ROR:  return {x[0], x[15:1]};
      default:     return x;
    endcase
  endfunction

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic rnd(output logic [15:0] v);
    seed = lfsr_next(seed);
    v = seed[15:0];
  endtask

  // An idle cycle, then one micro-step; results are settled on return
  task automatic run(input rbd_cmd_s m);
    @(posedge clk);
    #1;
    cmd = m;
    @(posedge clk);
    #1;
    cmd = '0;
  endtask

  task automatic load(input logic [15:0] d, input logic [4:0] st);
    io_in_data = d;
    io_in_en = 1'b1;
    run(mk(RBD_SRC_ZERO, RBD_SRC_ZERO, RBD_FN_PASS_R, st));
    io_in_en = 1'b0;
  endtask

  task automatic clr_flags();
    c = mk(RBD_SRC_ZERO, RBD_SRC_ZERO, RBD_FN_PASS_R, 5'h00);
    c.clear_ext = 1'b1;
    c.clear_ovf = 1'b1;
    run(c);
  endtask

  // Address comes through the second accumulator, write data from the first
  task automatic mem_cycle(input logic wr, input logic [ADDR_W-1:0] ad);
    load({3'h0, ad}, ST_B);
    run(mk(RBD_SRC_SECND, RBD_SRC_ZERO, RBD_FN_PASS_R, ST_MAR));
    c = mk(RBD_SRC_ZERO, RBD_SRC_ZERO, RBD_FN_PASS_R, 5'h00);
    c.mem_start = 1'b1;
    c.mem_write = wr;
    busy_cnt = 0;
    run(c);
    @(posedge clk);
    #1;
    `CHK(mdr, WORD_ZERO)
    if (wr)
    begin
      repeat (140) @(posedge clk);
      run(mk(RBD_SRC_FIRST, RBD_SRC_ZERO, RBD_FN_PASS_R, ST_MDR));
    end
    n = 0;
    while (mem_busy !== 1'b0 && n < 1000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(busy_cnt, 250)
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ************************************************************
  // Clock, busy counter and watchdog
  // ************************************************************
  always #4 clk = ~clk;

  always @(negedge clk)
  begin
    busy_cnt += int'(mem_busy === 1'b1);
    cyc++;
    if (cyc == 12000)
    begin
      miscompares++;
      close_out();
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    cmd = '0;
    io_in_en = 1'b0;
    io_in_data = '0;
    seed = 32'd70900;
    fl = '{RBD_FN_AND, RBD_FN_XOR, RBD_FN_IOR, RBD_FN_CMPL,
           RBD_FN_SHL, RBD_FN_SHR, RBD_FN_ROL, RBD_FN_ROR};
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    `CHK({first_acc, second_acc, pc, mar, mdr, ext_flag, ovf_flag}, '0)
    for (i = 0; i < 24; i++)
    begin
      rnd(a);
      rnd(b);
      if (i == 20) {a, b} = {16'h7fff, 16'h0001};
      if (i == 21) {a, b} = {16'h8000, 16'h8000};
      if (i == 22) {a, b} = {16'hffff, 16'h0001};
      if (i == 23) {a, b} = {16'h4000, 16'hc000};
      load(a, ST_A);
      load(b, ST_B);
      clr_flags();
      run(mk(RBD_SRC_FIRST, RBD_SRC_SECND, RBD_FN_ADD, ST_A));
      sum = {1'b0, a} + {1'b0, b};
      `CHK(first_acc, sum[15:0])
      `CHK(ext_flag, sum[16])
      `CHK(ovf_flag, (a[15] == b[15]) && (sum[15] != a[15]))
    end
    clr_flags();
    `CHK({ext_flag, ovf_flag}, 2'b00)
    for (i = 0; i < 8; i++)
    begin
      rnd(a);
      rnd(b);
      load(a, ST_A);
      load(b, ST_B);
      run(mk(RBD_SRC_FIRST, RBD_SRC_SECND, fl[i], ST_A));
      `CHK(first_acc, exp_fn(fl[i], a, b))
      run(mk(RBD_SRC_SECND, RBD_SRC_FIRST, fl[i], ST_B));
      `CHK(second_acc, (i < 3) ? b : exp_fn(fl[i], b, a))
    end
    load(b, ST_A | ST_B);
    run(mk(RBD_SRC_FIRST, RBD_SRC_SECND, RBD_FN_CMPEQ, 5'h00));
    `CHK(cmp_equal, 1'b1)
    load(b ^ 16'h0001, ST_A);
    run(mk(RBD_SRC_FIRST, RBD_SRC_SECND, RBD_FN_CMPEQ, 5'h00));
    `CHK(cmp_equal, 1'b0)
    rnd(a);
    a[15] = 1'b1;
    rnd(b);
    load(a, ST_A);
    load(b, ST_B);
    clr_flags();
    run(mk(RBD_SRC_FIRST, RBD_SRC_SECND, RBD_FN_ROL32, ST_A));
    `CHK(first_acc, {a[14:0], b[15]})
    `CHK(ext_flag, 1'b1)
    run(mk(RBD_SRC_SECND, RBD_SRC_ZERO, RBD_FN_ROR32, ST_B));
    `CHK({second_acc, ext_flag}, {1'b1, b})
    rnd(a);
    rnd(b);
    load(a, ST_A);
    load(b, ST_B);
    run(mk(RBD_SRC_FIRST, RBD_SRC_ZERO, RBD_FN_PASS_R, ST_PC));
    `CHK(pc, a)
    run(mk(RBD_SRC_PC, RBD_SRC_ZERO, RBD_FN_INC, ST_PC));
    `CHK(pc, a + 16'h0001)
    run(mk(RBD_SRC_PC, RBD_SRC_ZERO, RBD_FN_INC2, ST_PC));
    `CHK(pc, a + 16'h0003)
    run(mk(RBD_SRC_PC, RBD_SRC_ZERO, RBD_FN_PASS_R, ST_MAR));
    `CHK(mar, a[12:0] + 13'h0003)
    run(mk(RBD_SRC_SECND, RBD_SRC_ZERO, RBD_FN_PASS_R, ST_MAR));
    `CHK({pc, mar}, {a + 16'h0003, b[12:0]})
    run(mk(RBD_SRC_PC, RBD_SRC_ZERO, RBD_FN_INC, ST_PC | ST_MAR));
    `CHK({pc, mar}, {a + 16'h0004, a[12:0] + 13'h0004})
    run(mk(RBD_SRC_ZERO, RBD_SRC_MAR, RBD_FN_PASS_S, ST_B));
    `CHK(second_acc, {3'h0, a[12:0] + 13'h0004})
    adr = '{13'h1234, 13'h0234, 13'h0000};
    rnd(a);
    adr[2] = a[12:0] | 13'h0002;
    for (i = 0; i < 3; i++)
    begin
      rnd(dat[i]);
      load(dat[i], ST_A);
      mem_cycle(1'b1, adr[i]);
      u_rbd_mem_model.put(adr[i], dat[i]);
    end
    for (i = 0; i < 4; i++)
    begin
      mem_cycle(1'b0, (i < 3) ? adr[i] : ADDR_FIRST_ACC);
      a = u_rbd_mem_model.get((i < 3) ? adr[i] : ADDR_FIRST_ACC, dat[2], 16'h0000);
      `CHK(mdr, a)
      `CHK(parity_err, 1'b0)
    end
    run(mk(RBD_SRC_FIRST, RBD_SRC_MDR, RBD_FN_ADD, ST_A));
    `CHK(first_acc, dat[2] + dat[2])
    rst_n = 1'b0;
    #1;
    `CHK({first_acc, pc, mdr, ext_flag, ovf_flag, mem_busy}, '0)
    close_out();
  end

endmodule // tb_top

`default_nettype wire
